/* File: fgv_consts.svh */
// Behaviour
// R01 - Group capability query returns zero output delay.
// R02 - Full-on and off supported, middle states not.
// R03 - Extended low power and clock-stopped off set.
// R04 - Independent clock flag reads zero.
// R05 - Report 96 and 48 MHz; 48 always one.
// R06 - 24, 12 and 6 MHz flags read zero.
// R07 - 192 MHz capability flag reads zero.
// R08 - Controller requests only full-on or off.
// R09 - Report echoes last requested power state.
// R10 - Report actual power state; resets to 11.
// R11 - Settings cleared flag always zero.
// R12 - Clock halt permitted flag always one.
// R13 - Power state error flag always zero.
// R14 - Identifier read returns full 32-bit value.
// R15 - Byte write verbs fill identifier bytes.
// R16 - Rate select payload bits 5:0, 7:6 reserved.
// R17 - Rate report shows rate flags, upper zero.
// R18 - Group reset restores power-on values.
// R19 - Group reset keeps identifier and defaults.
// R20 - Group reset leaves link logic alone.
// R21 - Never raise a status change request.
// R22 - Verbs are addressed to node 01h.
// R23 - Answer every verb; unsupported answers zero.
`ifndef FGV_CONSTS_SVH
`define FGV_CONSTS_SVH

// ----------------------------------------------------------------------
// Node and verb codes
// ----------------------------------------------------------------------
`define FGV_NODE_GROUP          8'h01
`define FGV_VERB_GET_PARAM      12'hF00
`define FGV_VERB_SET_POWER      12'h705
`define FGV_VERB_GET_POWER      12'hF05
`define FGV_VERB_SET_ID_BASE    10'h1C8
`define FGV_VERB_GET_ID_BASE    10'h3C8
`define FGV_VERB_SET_RATE       12'h724
`define FGV_VERB_GET_RATE       12'hF24
`define FGV_VERB_GROUP_RESET    12'h7FF

// ----------------------------------------------------------------------
// Parameter identifiers and their answers
// ----------------------------------------------------------------------
`define FGV_PARAM_GROUP_CAP     8'h08
`define FGV_PARAM_POWER_STATES  8'h0F
`define FGV_PARAM_LINK_CAPS     8'h16
`define FGV_GROUP_CAP_VALUE     32'h0000_0000
`define FGV_POWER_STATES_VALUE  32'hC000_0009
`define FGV_LINK_CAPS_VALUE     32'h0000_0018

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define FGV_PS_REQ_LSB          0
`define FGV_PS_ACT_LSB          4
`define FGV_PS_ERR_BIT          8
`define FGV_PS_CLOCK_HALT_PERMITTED_BIT         9
`define FGV_PS_SR_BIT           10
`define FGV_PS_RESET            2'h3
`define FGV_RATE_RESET          6'h00
`define FGV_CMD_NODE_LSB        20
`define FGV_CMD_VERB_LSB        8

`endif

/* File: fgv_pkg.sv */
package fgv_pkg;

  // ----------------------------------------------------------------------
  // State of the link-facing logic
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        req_tgl;
    logic [27:0] cmd;
    logic        ack_s1;
    logic        ack_s2;
    logic        ack_s3;
    logic        busy;
    logic        resp_valid;
    logic [31:0] resp_data;
    logic        stat_chg;
  } fgv_link_state_t;

  // ----------------------------------------------------------------------
  // State of the core-clock verb logic
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        req_s1;
    logic        req_s2;
    logic        req_s3;
    logic        ack_tgl;
    logic [31:0] resp;
    logic [1:0]  req_ps;
    logic [1:0]  act_ps;
    logic [31:0] subsystem_identifier;
    logic [5:0]  clk_sel;
    logic        fg_rst;
  } fgv_core_state_t;

endpackage : fgv_pkg

/* File: fgv_function_group_verbs.sv */
`timescale 1ns/100ps
`include "fgv_consts.svh"

module fgv_function_group_verbs
#(
  // Arbitrary neutral power-on subsystem identifier.
  parameter logic [31:0] SUBSYS_ID_RESET = 32'h5A5A_0001
)
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        link_clk,
  input  wire logic        link_rst_n,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_node,
  input  wire logic [11:0] cmd_verb,
  input  wire logic [7:0]  cmd_payload,
  output logic             cmd_busy,
  output logic             resp_valid,
  output logic [31:0]      resp_data,
  output logic             status_change_req,
  output logic [1:0]       power_state,
  output logic [5:0]       clock_rate_sel,
  output logic             group_reset_pulse
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] fgv_param_word(input logic [7:0] param);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (param)
      `FGV_PARAM_GROUP_CAP:    w = `FGV_GROUP_CAP_VALUE;    // see R01
      `FGV_PARAM_POWER_STATES: w = `FGV_POWER_STATES_VALUE; // see R02 see R03
      `FGV_PARAM_LINK_CAPS:    w = `FGV_LINK_CAPS_VALUE;    // see R04 see R05 see R06 see R07
      default:                 w = 32'h0000_0000;           // see R23
    endcase
    return w;
  endfunction : fgv_param_word

  function automatic logic [31:0] fgv_power_word(input logic [1:0] req,
                                                 input logic [1:0] act);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`FGV_PS_REQ_LSB +: 2] = req;                          // see R09
    w[`FGV_PS_ACT_LSB +: 2] = act;                          // see R10
    w[`FGV_PS_ERR_BIT]      = 1'b0;                         // see R13
    w[`FGV_PS_CLOCK_HALT_PERMITTED_BIT]     = 1'b1;                         // see R12
    w[`FGV_PS_SR_BIT]       = 1'b0;                         // see R11
    return w;
  endfunction : fgv_power_word

  // ----------------------------------------------------------------------
  // Link-facing logic
  // ----------------------------------------------------------------------
  fgv_pkg::fgv_link_state_t link_q;
  fgv_pkg::fgv_link_state_t link_nxt;
  fgv_pkg::fgv_core_state_t core_q;
  fgv_pkg::fgv_core_state_t core_nxt;

  // The command word stays frozen while busy, so the core may read it
  // once the request toggle has crossed.
  always_comb
  begin
    link_nxt            = link_q;
    link_nxt.ack_s1     = core_q.ack_tgl;
    link_nxt.ack_s2     = link_q.ack_s1;
    link_nxt.ack_s3     = link_q.ack_s2;
    link_nxt.resp_valid = 1'b0;
    link_nxt.stat_chg   = 1'b0;                             // see R21
    // A toggle that arrives while idle comes from a core reset, not from an
    // answer, so it is dropped rather than shown as a phantom response.
    if (link_q.busy && (link_q.ack_s2 != link_q.ack_s3))    // see R20
    begin
      link_nxt.resp_data  = core_q.resp;
      link_nxt.resp_valid = 1'b1;
      link_nxt.busy       = 1'b0;
    end
    if (cmd_valid && !link_q.busy)
    begin
      link_nxt.cmd     = {cmd_node, cmd_verb, cmd_payload};
      link_nxt.req_tgl = ~link_q.req_tgl;
      link_nxt.busy    = 1'b1;
    end
  end

  // Only the link reset clears this side; a group reset never reaches it.
  always_ff @(posedge link_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      link_q <= '0;                                         // see R20
    end
    else
    begin
      link_q <= link_nxt;
    end
  end

  assign cmd_busy          = link_q.busy;
  assign resp_valid        = link_q.resp_valid;
  assign resp_data         = link_q.resp_data;
  assign status_change_req = link_q.stat_chg;

  // ----------------------------------------------------------------------
  // Core verb logic
  // ----------------------------------------------------------------------
  logic        exec;
  logic [7:0]  c_node;
  logic [11:0] c_verb;
  logic [7:0]  c_pay;

  assign exec   = core_q.req_s2 ^ core_q.req_s3;
  assign c_node = link_q.cmd[`FGV_CMD_NODE_LSB +: 8];
  assign c_verb = link_q.cmd[`FGV_CMD_VERB_LSB +: 12];
  assign c_pay  = link_q.cmd[7:0];

  always_comb
  begin
    core_nxt        = core_q;
    core_nxt.req_s1 = link_q.req_tgl;
    core_nxt.req_s2 = core_q.req_s1;
    core_nxt.req_s3 = core_q.req_s2;
    core_nxt.act_ps = core_q.req_ps;
    core_nxt.fg_rst = 1'b0;
    if (exec)
    begin
      core_nxt.ack_tgl = ~core_q.ack_tgl;
      core_nxt.resp    = 32'h0000_0000;                     // see R23
      if (c_node == `FGV_NODE_GROUP)                        // see R22
      begin
        if (c_verb[11:2] == `FGV_VERB_SET_ID_BASE)
        begin
          core_nxt.subsystem_identifier[{c_verb[1:0], 3'h0} +: 8] = c_pay;  // see R15
        end
        else if (c_verb[11:2] == `FGV_VERB_GET_ID_BASE)
        begin
          core_nxt.resp = core_q.subsystem_identifier;                      // see R14
        end
        else
        begin
          case (c_verb)
            `FGV_VERB_GET_PARAM:
            begin
              core_nxt.resp = fgv_param_word(c_pay);
            end
            `FGV_VERB_SET_POWER:
            begin
              core_nxt.req_ps = c_pay[1:0];                 // see R09
            end
            `FGV_VERB_GET_POWER:
            begin
              core_nxt.resp = fgv_power_word(core_q.req_ps, core_q.act_ps);
            end
            `FGV_VERB_SET_RATE:
            begin
              core_nxt.clk_sel = c_pay[5:0];                // see R16
            end
            `FGV_VERB_GET_RATE:
            begin
              core_nxt.resp = {26'h0, core_q.clk_sel};      // see R17
            end
            `FGV_VERB_GROUP_RESET:
            begin
              // The identifier is board configuration and survives.
              core_nxt.req_ps  = `FGV_PS_RESET;             // see R18
              core_nxt.act_ps  = `FGV_PS_RESET;
              core_nxt.clk_sel = `FGV_RATE_RESET;           // see R19
              core_nxt.fg_rst  = 1'b1;
            end
            default:
            begin
              core_nxt.resp = 32'h0000_0000;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_q         <= '0;
      core_q.req_ps  <= `FGV_PS_RESET;                      // see R10
      core_q.act_ps  <= `FGV_PS_RESET;
      core_q.subsystem_identifier    <= SUBSYS_ID_RESET;
      core_q.clk_sel <= `FGV_RATE_RESET;
    end
    else
    begin
      core_q <= core_nxt;
    end
  end

  assign power_state       = core_q.act_ps;
  assign clock_rate_sel    = core_q.clk_sel;
  assign group_reset_pulse = core_q.fg_rst;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic hit;
  assign hit = exec && (c_node == `FGV_NODE_GROUP);

  a_group_cap_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // see R01
    (hit && c_verb == `FGV_VERB_GET_PARAM && c_pay == `FGV_PARAM_GROUP_CAP)
    |=> (core_q.resp == 32'h0000_0000))
    else $error("Group capability answer not zero.");

  a_power_states_word: assert property (@(posedge core_clk) disable iff (!rst_n) // see R02
    (hit && c_verb == `FGV_VERB_GET_PARAM && c_pay == `FGV_PARAM_POWER_STATES)
    |=> (core_q.resp[3:0] == 4'h9 && core_q.resp[31:30] == 2'h3))
    else $error("Supported power states answer wrong.");

  a_link_caps_word: assert property (@(posedge core_clk) disable iff (!rst_n) // see R05
    (hit && c_verb == `FGV_VERB_GET_PARAM && c_pay == `FGV_PARAM_LINK_CAPS)
    |=> (core_q.resp == 32'h0000_0018))
    else $error("Extended link capability answer wrong.");

  a_unknown_param: assert property (@(posedge core_clk) disable iff (!rst_n) // see R23
    (hit && c_verb == `FGV_VERB_GET_PARAM && c_pay != `FGV_PARAM_GROUP_CAP &&
     c_pay != `FGV_PARAM_POWER_STATES && c_pay != `FGV_PARAM_LINK_CAPS)
    |=> (core_q.resp == 32'h0000_0000))
    else $error("Unsupported parameter answered non-zero.");

  a_power_set_seen: assert property (@(posedge core_clk) disable iff (!rst_n) // see R09
    (hit && c_verb == `FGV_VERB_SET_POWER)
    |=> (core_q.req_ps == $past(c_pay[1:0])) ##1 (core_q.act_ps == $past(core_q.req_ps)))
    else $error("Power request not stored or not followed.");

  a_power_report: assert property (@(posedge core_clk) disable iff (!rst_n) // see R12
    (hit && c_verb == `FGV_VERB_GET_POWER)
    |=> (core_q.resp[10:8] == 3'h2 && core_q.resp[1:0] == $past(core_q.req_ps) &&
         core_q.resp[5:4] == $past(core_q.act_ps)))
    else $error("Power state report wrong.");

  a_id_byte_write: assert property (@(posedge core_clk) disable iff (!rst_n) // see R15
    (hit && c_verb == 12'h722)
    |=> (core_q.subsystem_identifier[23:16] == $past(c_pay) && core_q.subsystem_identifier[15:0] == $past(core_q.subsystem_identifier[15:0])))
    else $error("Identifier byte write misplaced.");

  a_rate_roundtrip: assert property (@(posedge core_clk) disable iff (!rst_n) // see R17
    (hit && c_verb == `FGV_VERB_GET_RATE)
    |=> (core_q.resp == {26'h0, $past(core_q.clk_sel)}))
    else $error("Clock rate report wrong.");

  a_group_reset_vals: assert property (@(posedge core_clk) disable iff (!rst_n) // see R18
    (hit && c_verb == `FGV_VERB_GROUP_RESET)
    |=> (core_q.req_ps == 2'h3 && core_q.act_ps == 2'h3 && core_q.clk_sel == 6'h00 &&
         core_q.subsystem_identifier == $past(core_q.subsystem_identifier) && core_q.fg_rst))
    else $error("Group reset did not restore values.");

  a_status_quiet: assert property (@(posedge link_clk) disable iff (!link_rst_n) // see R21
    !link_q.stat_chg)
    else $error("Status change request raised.");

  a_link_answer: assert property (@(posedge link_clk) disable iff (!link_rst_n) // see R23
    (cmd_valid && !link_q.busy) |=> link_q.busy ##[1:14] link_q.resp_valid)
    else $error("Verb not answered in time.");

  // Decodes shared by the checks below.
  logic hit_param;
  logic hit_power;
  logic link_ans;
  assign hit_param = hit && (c_verb == `FGV_VERB_GET_PARAM);
  assign hit_power = hit && (c_verb == `FGV_VERB_GET_POWER);
  assign link_ans  = link_q.ack_s2 != link_q.ack_s3;

  a_middle_states_off: assert property (@(posedge core_clk) disable iff (!rst_n) // see R02
    (hit_param && c_pay == `FGV_PARAM_POWER_STATES) |=> (core_q.resp[2:1] == 2'h0))
    else $error("Intermediate power states reported.");

  a_ext_power_bits: assert property (@(posedge core_clk) disable iff (!rst_n) // see R03
    (hit_param && c_pay == `FGV_PARAM_POWER_STATES)
    |=> (core_q.resp[31:30] == 2'h3 && core_q.resp[29:4] == 26'h0))
    else $error("Extended power bits wrong.");

  a_indep_clock_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // see R04
    (hit_param && c_pay == `FGV_PARAM_LINK_CAPS) |=> (core_q.resp[16] == 1'b0))
    else $error("Independent clock flag set.");

  a_rate_48_set: assert property (@(posedge core_clk) disable iff (!rst_n) // see R05
    (hit_param && c_pay == `FGV_PARAM_LINK_CAPS) |=> (core_q.resp[4:3] == 2'h3))
    else $error("96 or 48 MHz support flag clear.");

  a_low_rates_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // see R06
    (hit_param && c_pay == `FGV_PARAM_LINK_CAPS) |=> (core_q.resp[2:0] == 3'h0))
    else $error("Low rate support flag set.");

  a_rate_192_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // see R07
    (hit_param && c_pay == `FGV_PARAM_LINK_CAPS) |=> (core_q.resp[5] == 1'b0))
    else $error("192 MHz support flag set.");

  a_report_reserved: assert property (@(posedge core_clk) disable iff (!rst_n) // see R10
    hit_power |=> (core_q.resp[31:11] == 21'h0 && core_q.resp[7:6] == 2'h0 &&
                   core_q.resp[3:2] == 2'h0))
    else $error("Power report reserved bits set.");

  a_settings_flag: assert property (@(posedge core_clk) disable iff (!rst_n) // see R11
    hit_power |=> (core_q.resp[10] == 1'b0))
    else $error("Settings cleared flag set.");

  a_error_flag: assert property (@(posedge core_clk) disable iff (!rst_n) // see R13
    hit_power |=> (core_q.resp[8] == 1'b0))
    else $error("Power error flag set.");

  a_id_read_whole: assert property (@(posedge core_clk) disable iff (!rst_n) // see R14
    (hit && c_verb[11:2] == `FGV_VERB_GET_ID_BASE) |=> (core_q.resp == $past(core_q.subsystem_identifier)))
    else $error("Identifier read wrong.");

  a_id_byte_low: assert property (@(posedge core_clk) disable iff (!rst_n) // see R15
    (hit && c_verb == 12'h720)
    |=> (core_q.subsystem_identifier[7:0] == $past(c_pay) && core_q.subsystem_identifier[31:8] == $past(core_q.subsystem_identifier[31:8])))
    else $error("Identifier low byte write misplaced.");

  a_id_byte_high: assert property (@(posedge core_clk) disable iff (!rst_n) // see R15
    (hit && c_verb == 12'h723)
    |=> (core_q.subsystem_identifier[31:24] == $past(c_pay) && core_q.subsystem_identifier[23:0] == $past(core_q.subsystem_identifier[23:0])))
    else $error("Identifier high byte write misplaced.");

  a_rate_select: assert property (@(posedge core_clk) disable iff (!rst_n) // see R16
    (hit && c_verb == `FGV_VERB_SET_RATE) |=> (core_q.clk_sel == $past(c_pay[5:0])))
    else $error("Clock rate select not stored.");

  a_rate_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // see R17
    (hit && c_verb == `FGV_VERB_GET_RATE) |=> (core_q.resp[31:6] == 26'h0))
    else $error("Clock rate report upper bits set.");

  a_reset_pulse_once: assert property (@(posedge core_clk) disable iff (!rst_n) // see R18
    core_q.fg_rst |=> !core_q.fg_rst)
    else $error("Group reset pulse too long.");

  a_reset_keeps_id: assert property (@(posedge core_clk) disable iff (!rst_n) // see R19
    (hit && c_verb == `FGV_VERB_GROUP_RESET) |=> (core_q.subsystem_identifier == $past(core_q.subsystem_identifier)))
    else $error("Group reset changed the identifier.");

  a_other_node_quiet: assert property (@(posedge core_clk) disable iff (!rst_n) // see R22
    (exec && c_node != `FGV_NODE_GROUP)
    |=> (core_q.resp == 32'h0 && core_q.req_ps == $past(core_q.req_ps) &&
         core_q.subsystem_identifier == $past(core_q.subsystem_identifier) && core_q.clk_sel == $past(core_q.clk_sel)))
    else $error("Verb for another node had an effect.");

  a_exec_acks: assert property (@(posedge core_clk) disable iff (!rst_n) // see R23
    exec |=> (core_q.ack_tgl != $past(core_q.ack_tgl)))
    else $error("Executed verb not acknowledged.");

  a_set_answers_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // see R23
    (hit && c_verb == `FGV_VERB_SET_POWER) |=> (core_q.resp == 32'h0))
    else $error("Set verb answered non-zero.");

  a_resp_one_cycle: assert property (@(posedge link_clk) disable iff (!link_rst_n) // see R23
    link_q.resp_valid |=> !link_q.resp_valid)
    else $error("Response strobe longer than one cycle.");

  a_busy_to_answer: assert property (@(posedge link_clk) disable iff (!link_rst_n) // see R23
    $fell(link_q.busy) |-> link_q.resp_valid)
    else $error("Busy dropped without an answer.");

  a_stale_ack_ignored: assert property (@(posedge link_clk) disable iff (!link_rst_n) // see R20
    (!link_q.busy && link_ans) |=> !link_q.resp_valid)
    else $error("Answer shown with no verb outstanding.");

endmodule : fgv_function_group_verbs

/* File: fgv_link_ctrl_model.sv */
`timescale 1ns/100ps

module fgv_link_ctrl_model
(
  input  wire logic        link_clk,
  output logic             cmd_valid,
  output logic [7:0]       cmd_node,
  output logic [11:0]      cmd_verb,
  output logic [7:0]       cmd_payload,
  input  wire logic        cmd_busy,
  input  wire logic        resp_valid,
  input  wire logic [31:0] resp_data
);

  initial
  begin
    cmd_valid   = 1'b0;
    cmd_node    = 8'h00;
    cmd_verb    = 12'h000;
    cmd_payload = 8'h00;
  end

  // ----------------------------------------------------------------------
  // One verb, one answer
  // ----------------------------------------------------------------------
  // Callers pass node 01h or 02h and power requests of 00 or 11 only.
  task automatic send_verb(input logic [7:0] node, input logic [11:0] verb,
                           input logic [7:0] pay, output logic [31:0] resp);
    int n;
    n    = 0;
    resp = 32'hXXXX_XXXX;
    @(negedge link_clk);
    while (cmd_busy !== 1'b0 && n < 20)
    begin
      @(negedge link_clk);
      n++;
    end
    cmd_valid   = 1'b1;
    cmd_node    = node;
    cmd_verb    = verb;
    cmd_payload = pay;
    @(negedge link_clk);
    // Idle fields carry garbage so a design that samples late is caught.
    cmd_valid   = 1'b0;
    cmd_node    = ~node;
    cmd_verb    = ~verb;
    cmd_payload = ~pay;
    n           = 0;
    while (n < 20)
    begin
      @(negedge link_clk);
      if (resp_valid === 1'b1)
      begin
        resp = resp_data;
        n    = 20;
      end
      n++;
    end
  endtask : send_verb

endmodule : fgv_link_ctrl_model

/* File: fgv_function_group_verbs_test.sv */
`timescale 1ns/100ps

module fgv_function_group_verbs_test;

  typedef struct packed {
    logic [7:0]  node;
    logic [11:0] verb;
    logic [7:0]  pay;
    logic [31:0] exp;
  } fgv_row_t;

  // Arbitrary identifier value.
  localparam logic [31:0] ID_RESET = 32'h1234_ABCD;

  logic        core_clk   = 1'b0;
  logic        link_clk   = 1'b0;
  logic        rst_n      = 1'b0;
  logic        link_rst_n = 1'b0;
  logic        cmd_valid;
  logic [7:0]  cmd_node;
  logic [11:0] cmd_verb;
  logic [7:0]  cmd_payload;
  logic        cmd_busy;
  logic        resp_valid;
  logic [31:0] resp_data;
  logic        status_change_req;
  logic [1:0]  power_state;
  logic [5:0]  clock_rate_sel;
  logic        group_reset_pulse;
  logic [31:0] resp;
  int          errors     = 0;
  int          n_compared = 0;
  int          cycles     = 0;
  int          n_pulse    = 0;
  fgv_row_t    rows [24];

  always #25 core_clk = ~core_clk;
  always #24 link_clk = ~link_clk;

  fgv_function_group_verbs #(.SUBSYS_ID_RESET(ID_RESET)) u_fgv_function_group_verbs
  (
    .core_clk          (core_clk),
    .rst_n             (rst_n),
    .link_clk          (link_clk),
    .link_rst_n        (link_rst_n),
    .cmd_valid         (cmd_valid),
    .cmd_node          (cmd_node),
    .cmd_verb          (cmd_verb),
    .cmd_payload       (cmd_payload),
    .cmd_busy          (cmd_busy),
    .resp_valid        (resp_valid),
    .resp_data         (resp_data),
    .status_change_req (status_change_req),
    .power_state       (power_state),
    .clock_rate_sel    (clock_rate_sel),
    .group_reset_pulse (group_reset_pulse)
  );

  fgv_link_ctrl_model u_fgv_link_ctrl_model
  (
    .link_clk    (link_clk),
    .cmd_valid   (cmd_valid),
    .cmd_node    (cmd_node),
    .cmd_verb    (cmd_verb),
    .cmd_payload (cmd_payload),
    .cmd_busy    (cmd_busy),
    .resp_valid  (resp_valid),
    .resp_data   (resp_data)
  );

  // ----------------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------------
  task automatic cmp_resp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_resp

  task automatic cmp_core(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_core

  task automatic close_out();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  task automatic run(input fgv_row_t r);
    u_fgv_link_ctrl_model.send_verb(r.node, r.verb, r.pay, resp);
    cmp_resp(resp, r.exp);
    cmp_core({7'h00, status_change_req}, 8'h00);
  endtask : run

  always @(negedge core_clk)
  begin
    if (group_reset_pulse === 1'b1)
      n_pulse++;
  end

  // 29 verbs of at most 42 link cycles each stay far below this.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      close_out();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    rows = '{
      '{8'h01, 12'hF00, 8'h08, 32'h0000_0000},
      '{8'h01, 12'hF00, 8'h0F, 32'hC000_0009},
      '{8'h01, 12'hF00, 8'h16, 32'h0000_0018},
      '{8'h01, 12'hF00, 8'h0A, 32'h0000_0000},
      '{8'h01, 12'hF05, 8'h00, 32'h0000_0233},
      '{8'h01, 12'hF24, 8'h00, 32'h0000_0000},
      '{8'h01, 12'h720, 8'h11, 32'h0000_0000},
      '{8'h01, 12'h721, 8'h22, 32'h0000_0000},
      '{8'h01, 12'h722, 8'h33, 32'h0000_0000},
      '{8'h01, 12'h723, 8'h44, 32'h0000_0000},
      '{8'h01, 12'hF20, 8'h00, 32'h4433_2211},
      '{8'h01, 12'hF23, 8'h00, 32'h4433_2211},
      '{8'h01, 12'h705, 8'h00, 32'h0000_0000},
      '{8'h01, 12'hF05, 8'h00, 32'h0000_0200},
      '{8'h01, 12'h724, 8'h10, 32'h0000_0000},
      '{8'h01, 12'hF24, 8'h00, 32'h0000_0010},
      '{8'h02, 12'h705, 8'h03, 32'h0000_0000},
      '{8'h01, 12'hF05, 8'h00, 32'h0000_0200},
      '{8'h01, 12'h705, 8'h03, 32'h0000_0000},
      '{8'h01, 12'hF05, 8'h00, 32'h0000_0233},
      '{8'h01, 12'h724, 8'h08, 32'h0000_0000},
      '{8'h01, 12'hF24, 8'h00, 32'h0000_0008},
      '{8'h01, 12'h705, 8'h00, 32'h0000_0000},
      '{8'h01, 12'h724, 8'h20, 32'h0000_0000}
    };
    repeat (2) @(negedge core_clk);
    rst_n      = 1'b1;
    link_rst_n = 1'b1;
    repeat (5) @(negedge core_clk);
    cmp_core({6'h00, power_state}, 8'h03);
    cmp_core({2'h0, clock_rate_sel}, 8'h00);
    foreach (rows[i])
      run(rows[i]);
    cmp_core({6'h00, power_state}, 8'h00);
    cmp_core({2'h0, clock_rate_sel}, 8'h20);
    run(fgv_row_t'{8'h01, 12'h7FF, 8'h00, 32'h0000_0000});
    repeat (4) @(negedge core_clk);
    cmp_core(n_pulse[7:0], 8'h01);
    cmp_core({6'h00, power_state}, 8'h03);
    cmp_core({2'h0, clock_rate_sel}, 8'h00);
    run(fgv_row_t'{8'h01, 12'hF05, 8'h00, 32'h0000_0233});
    run(fgv_row_t'{8'h01, 12'hF22, 8'h00, 32'h4433_2211});
    // A core reset in mid-run must leave the link side answering.
    @(negedge core_clk);
    rst_n = 1'b0;
    @(negedge core_clk);
    rst_n = 1'b1;
    // Let the core replay of the last held command drain before the next verb.
    repeat (12) @(negedge core_clk);
    run(fgv_row_t'{8'h01, 12'hF21, 8'h00, ID_RESET});
    run(fgv_row_t'{8'h01, 12'hF00, 8'h0F, 32'hC000_0009});
    close_out();
  end

endmodule : fgv_function_group_verbs_test
